/* File: gmsp_top.sv */
// Purpose: Serial port of the navigation receiver: sentence output, command input.
// Assumes: Host keeps the same bit rate; no handshake lines exist.
// Notes:   A rate change takes effect at once and may corrupt a character in flight.
`timescale 1ns/1ns
module gmsp_top
    import gmsp_pkg::*;
#(
    parameter int unsigned CLK_HZ = GMSP_CLK_HZ
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    input  wire logic       ce_in,
    input  wire logic       rxd_in,
    output logic            txd_out,
    input  wire logic       nav_update_in,
    input  wire logic [7:0] body_data_in,
    input  wire logic       body_valid_in,
    input  wire logic       body_last_in,
    output logic            body_ready_out,
    output logic [2:0]      type_idx_out,
    output logic            busy_out,
    output logic [7:0]      cmd_data_out,
    output logic            cmd_valid_out,
    output logic            frame_err_out,
    output logic [2:0]      baud_code_out,
    output logic [6:0]      type_mask_out
);
    typedef struct packed {
        gmsp_sent_e  sst;
        logic [2:0]  ty;
        logic [2:0]  pos;
        logic [7:0]  csum;
        logic        pend;
        logic [2:0]  baud;
        logic [6:0]  mask;
        gmsp_bit_e   tst;
        logic [15:0] tcnt;
        logic [2:0]  tbit;
        logic [7:0]  tsh;
        logic        txd;
    } gmsp_top_s;

    gmsp_top_s r;
    gmsp_top_s r_nxt;
    gmsp_rx_if rxi ();

    logic [15:0] div;
    logic [7:0]  ch;
    logic        ch_v;
    logic        tx_idle;
    logic        acc;
    logic        cmd_v;

    assign div     = gmsp_div(CLK_HZ, r.baud);
    assign rxi.div = div;

    gmsp_uart_rx u_rx (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .ce_in      (ce_in),
        .rxd_in     (rxd_in),
        .rxi        (rxi)
    );

    // Character source for the transmitter, picked by the sentence state.
    always_comb begin
        ch   = GMSP_CH_LF;
        ch_v = 1'b1;
        case (r.sst)
            GMSP_S_DOLLAR: ch = GMSP_CH_DOLLAR;
            GMSP_S_ADDR:   ch = gmsp_type_char(r.ty, r.pos);
            GMSP_S_COMMA:  ch = GMSP_CH_COMMA;
            GMSP_S_BODY: begin
                ch   = body_data_in;
                ch_v = body_valid_in;
            end
            GMSP_S_STAR:   ch = GMSP_CH_STAR;
            GMSP_S_HI:     ch = gmsp_hex(r.csum[7:4]);
            GMSP_S_LO:     ch = gmsp_hex(r.csum[3:0]);
            GMSP_S_CR:     ch = GMSP_CH_CR;
            GMSP_S_LF:     ch = GMSP_CH_LF;
            default:       ch_v = 1'b0;
        endcase
    end

    assign tx_idle = (r.tst == GMSP_B_IDLE);
    assign acc     = ce_in && tx_idle && ch_v;
    assign cmd_v   = ce_in && rxi.valid;

    always_comb begin
        r_nxt = r;
        if (ce_in) begin
            // Command bytes: high bit loads the type selection, 0x10 to 0x16 pick a rate.
            if (cmd_v && rxi.data[7]) begin
                r_nxt.mask = rxi.data[6:0];
            end else if (cmd_v && rxi.data[7:4] == GMSP_CMD_BAUD && !rxi.data[3]
                         && rxi.data[2:0] <= GMSP_BAUD_MAX) begin
                r_nxt.baud = rxi.data[2:0];
            end
            if (acc && r.sst inside {GMSP_S_ADDR, GMSP_S_COMMA, GMSP_S_BODY}) begin
                r_nxt.csum = r.csum ^ ch;
            end
            case (r.sst)
                GMSP_S_IDLE: begin
                    if (nav_update_in && !r.pend) begin
                        r_nxt.pend = 1'b1;
                        r_nxt.ty   = 3'h0;
                    end else if (r.pend) begin
                        if (r.mask[r.ty]) begin
                            r_nxt.sst = GMSP_S_DOLLAR;
                        end else if (r.ty == 3'(GMSP_NUM_TYPES - 1)) begin
                            r_nxt.pend = 1'b0;
                        end else begin
                            r_nxt.ty = r.ty + 3'h1;
                        end
                    end
                end
                GMSP_S_DOLLAR: if (acc) begin
                    r_nxt.sst  = GMSP_S_ADDR;
                    r_nxt.pos  = 3'h0;
                    r_nxt.csum = 8'h0;
                end
                GMSP_S_ADDR: if (acc) begin
                    r_nxt.pos = r.pos + 3'h1;
                    if (r.pos == GMSP_POS_LAST) begin
                        r_nxt.sst = GMSP_S_COMMA;
                    end
                end
                GMSP_S_COMMA: if (acc) r_nxt.sst = GMSP_S_BODY;
                GMSP_S_BODY:  if (acc && body_last_in) r_nxt.sst = GMSP_S_STAR;
                GMSP_S_STAR:  if (acc) r_nxt.sst = GMSP_S_HI;
                GMSP_S_HI:    if (acc) r_nxt.sst = GMSP_S_LO;
                GMSP_S_LO:    if (acc) r_nxt.sst = GMSP_S_CR;
                GMSP_S_CR:    if (acc) r_nxt.sst = GMSP_S_LF;
                GMSP_S_LF: begin
                    if (acc) begin
                        r_nxt.sst = GMSP_S_IDLE;
                        if (r.ty == 3'(GMSP_NUM_TYPES - 1)) begin
                            r_nxt.pend = 1'b0;
                        end else begin
                            r_nxt.ty = r.ty + 3'h1;
                        end
                    end
                end
                default: r_nxt.sst = GMSP_S_IDLE;
            endcase
            // Transmit bit engine, one divisor period per bit.
            if (r.tcnt != 16'h0) begin
                r_nxt.tcnt = r.tcnt - 16'h1;
            end
            case (r.tst)
                GMSP_B_IDLE: begin
                    r_nxt.txd = 1'b1;
                    if (acc) begin
                        r_nxt.tst  = GMSP_B_START;
                        r_nxt.tsh  = ch;
                        r_nxt.tcnt = div - 16'h1;
                        r_nxt.txd  = 1'b0;
                    end
                end
                GMSP_B_START: if (r.tcnt == 16'h0) begin
                    r_nxt.tst  = GMSP_B_DATA;
                    r_nxt.tbit = 3'h0;
                    r_nxt.txd  = r.tsh[0];
                    r_nxt.tcnt = div - 16'h1;
                end
                GMSP_B_DATA: if (r.tcnt == 16'h0) begin
                    r_nxt.tcnt = div - 16'h1;
                    if (r.tbit == GMSP_BIT_LAST) begin
                        r_nxt.tst = GMSP_B_STOP;
                        r_nxt.txd = 1'b1;
                    end else begin
                        r_nxt.tsh  = r.tsh >> 1;
                        r_nxt.txd  = r.tsh[1];
                        r_nxt.tbit = r.tbit + 3'h1;
                    end
                end
                GMSP_B_STOP: if (r.tcnt == 16'h0) r_nxt.tst = GMSP_B_IDLE;
                default: r_nxt.tst = GMSP_B_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r      <= '0;
            r.baud <= GMSP_BAUD_RST;
            r.mask <= GMSP_MASK_RST;
            r.txd  <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    // Only the two data lines exist; nothing here waits on the host.
    assign txd_out        = r.txd;
    assign body_ready_out = ce_in && tx_idle && (r.sst == GMSP_S_BODY);
    assign type_idx_out   = r.ty;
    assign busy_out       = r.pend;
    assign cmd_data_out   = rxi.data;
    assign cmd_valid_out  = rxi.valid;
    assign frame_err_out  = rxi.ferr;
    assign baud_code_out  = r.baud;
    assign type_mask_out  = r.mask;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence seq_take(gmsp_sent_e s);
        acc && r.sst == s;
    endsequence

    sequence seq_frame_open;
        r.tst == GMSP_B_START && !r.txd;
    endsequence

    AST_IDLE_HIGH: assert property (r.tst == GMSP_B_IDLE |-> txd_out)
        else $error("Transmit line not high while idle.");
    AST_START_LOW: assert property (acc |=> seq_frame_open)
        else $error("Accepted character did not open with a low start bit.");
    AST_STOP_HIGH: assert property (r.tst == GMSP_B_STOP |-> txd_out)
        else $error("Stop bit not high.");
    AST_DOLLAR: assert property (seq_take(GMSP_S_DOLLAR) |=> r.tsh == GMSP_CH_DOLLAR)
        else $error("Sentence did not open with a dollar.");
    AST_CSUM_LO: assert property (seq_take(GMSP_S_LO)
                                  |=> r.tsh == gmsp_hex($past(r.csum[3:0])))
        else $error("Checksum low digit wrong.");
    AST_BAUD_RANGE: assert property (r.baud <= GMSP_BAUD_MAX)
        else $error("Rate code out of range.");
    AST_BAUD_CMD: assert property (cmd_v && rxi.data[7:3] == 5'h02 && rxi.data[2:0] != 3'h7
                                   |=> r.baud == $past(rxi.data[2:0]))
        else $error("Rate command not applied.");
    AST_MASK_CMD: assert property (cmd_v && rxi.data[7] |=> r.mask == $past(rxi.data[6:0]))
        else $error("Selection command not applied.");
    // Judged at the scan step, as a selection command may legally land mid-sentence.
    AST_MASKED_TYPE: assert property (r.sst == GMSP_S_IDLE && r.pend && ce_in && !r.mask[r.ty]
                                      |=> r.sst != GMSP_S_DOLLAR)
        else $error("Deselected sentence type is being sent.");
    AST_LF_END: assert property (seq_take(GMSP_S_CR) |=> r.sst == GMSP_S_LF)
        else $error("Carriage return not followed by line feed state.");
endmodule

/* File: gmsp_pkg.sv */
// Purpose: Shared constants, types and helpers of the receiver serial port.
// Assumes: One 100 MHz system clock.
// Notes:   The sentence talker is fixed to the combined constellation prefix.
package gmsp_pkg;

    localparam int unsigned GMSP_CLK_HZ     = 100_000_000;
    localparam int unsigned GMSP_DATA_BITS  = 8;
    localparam int unsigned GMSP_NUM_TYPES  = 7;
    localparam logic [2:0]  GMSP_BAUD_RST   = 3'h5;
    localparam logic [2:0]  GMSP_BAUD_MAX   = 3'h6;
    localparam logic [6:0]  GMSP_MASK_RST   = 7'h7f;
    localparam logic [3:0]  GMSP_CMD_BAUD   = 4'h1;
    localparam logic [7:0]  GMSP_CH_DOLLAR  = 8'h24;
    localparam logic [7:0]  GMSP_CH_COMMA   = 8'h2c;
    localparam logic [7:0]  GMSP_CH_STAR    = 8'h2a;
    localparam logic [7:0]  GMSP_CH_CR      = 8'h0d;
    localparam logic [7:0]  GMSP_CH_LF      = 8'h0a;
    localparam logic [7:0]  GMSP_CH_G       = 8'h47;
    localparam logic [7:0]  GMSP_CH_N       = 8'h4e;
    localparam logic [2:0]  GMSP_POS_LAST   = 3'h4;
    localparam logic [2:0]  GMSP_BIT_LAST   = 3'h7;

    typedef enum logic [1:0] {
        GMSP_B_IDLE  = 2'h0,
        GMSP_B_START = 2'h1,
        GMSP_B_DATA  = 2'h3,
        GMSP_B_STOP  = 2'h2
    } gmsp_bit_e;

    typedef enum logic [3:0] {
        GMSP_S_IDLE   = 4'h0,
        GMSP_S_DOLLAR = 4'h1,
        GMSP_S_ADDR   = 4'h3,
        GMSP_S_COMMA  = 4'h2,
        GMSP_S_BODY   = 4'h6,
        GMSP_S_STAR   = 4'h7,
        GMSP_S_HI     = 4'h5,
        GMSP_S_LO     = 4'h4,
        GMSP_S_CR     = 4'hc,
        GMSP_S_LF     = 4'hd
    } gmsp_sent_e;

    function automatic logic [15:0] gmsp_div(input int unsigned clk_hz, input logic [2:0] code);
        int unsigned rate;
        case (code)
            3'h0:    rate = 9600;
            3'h1:    rate = 14400;
            3'h2:    rate = 19200;
            3'h3:    rate = 38400;
            3'h4:    rate = 57600;
            3'h6:    rate = 961200;
            default: rate = 115200;
        endcase
        return 16'(clk_hz / rate);
    endfunction

    function automatic logic [7:0] gmsp_hex(input logic [3:0] n);
        return (n < 4'ha) ? ({4'h0, n} + 8'h30) : ({4'h0, n} + 8'h37);
    endfunction

    function automatic logic [7:0] gmsp_type_char(input logic [2:0] ty, input logic [2:0] pos);
        logic [23:0] w;
        w = 24'h0;
        case (ty)
            3'h0:    w = "GGA";
            3'h1:    w = "GLL";
            3'h2:    w = "GSA";
            3'h3:    w = "GSV";
            3'h4:    w = "VTG";
            3'h5:    w = "RMC";
            default: w = "ZDA";
        endcase
        case (pos)
            3'h0:    return GMSP_CH_G;
            3'h1:    return GMSP_CH_N;
            3'h2:    return w[23:16];
            3'h3:    return w[15:8];
            default: return w[7:0];
        endcase
    endfunction

endpackage

/* File: gmsp_rx_if.sv */
// Purpose: Carries the bit divisor to the receiver and received bytes back.
// Assumes: Single clock domain.
// Notes:   Valid and frame error are one-cycle pulses while ce_in is high and hold while it is low.
`timescale 1ns/1ns
interface gmsp_rx_if;
    logic [15:0] div;
    logic [7:0]  data;
    logic        valid;
    logic        ferr;
    modport rx  (input div, output data, output valid, output ferr);
    modport top (output div, input data, input valid, input ferr);
endinterface

/* File: gmsp_uart_rx.sv */
// Purpose: Receive path of the serial port, one character at a time.
// Assumes: The receive line is synchronous to the clock.
// Notes:   A start bit that is gone at mid-bit is treated as a glitch.
`timescale 1ns/1ns
module gmsp_uart_rx
    import gmsp_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    input  wire logic ce_in,
    input  wire logic rxd_in,
    gmsp_rx_if.rx     rxi
);
    typedef struct packed {
        gmsp_bit_e   st;
        logic [15:0] cnt;
        logic [2:0]  bitn;
        logic [7:0]  sh;
        logic [7:0]  data;
        logic        valid;
        logic        ferr;
    } gmsp_rx_s;

    gmsp_rx_s r;
    gmsp_rx_s r_nxt;

    always_comb begin
        r_nxt = r;
        if (ce_in) begin
            r_nxt.valid = 1'b0;
            r_nxt.ferr  = 1'b0;
            if (r.cnt != 16'h0) begin
                r_nxt.cnt = r.cnt - 16'h1;
            end
            case (r.st)
                GMSP_B_IDLE: begin
                    if (!rxd_in) begin
                        r_nxt.st  = GMSP_B_START;
                        r_nxt.cnt = rxi.div >> 1;
                    end
                end
                GMSP_B_START: begin
                    if (r.cnt == 16'h0) begin
                        r_nxt.st   = rxd_in ? GMSP_B_IDLE : GMSP_B_DATA;
                        r_nxt.cnt  = rxi.div - 16'h1;
                        r_nxt.bitn = 3'h0;
                    end
                end
                GMSP_B_DATA: begin
                    if (r.cnt == 16'h0) begin
                        r_nxt.sh   = {rxd_in, r.sh[7:1]};
                        r_nxt.cnt  = rxi.div - 16'h1;
                        r_nxt.bitn = r.bitn + 3'h1;
                        if (r.bitn == GMSP_BIT_LAST) begin
                            r_nxt.st = GMSP_B_STOP;
                        end
                    end
                end
                GMSP_B_STOP: begin
                    if (r.cnt == 16'h0) begin
                        r_nxt.st    = GMSP_B_IDLE;
                        r_nxt.data  = r.sh;
                        r_nxt.valid = rxd_in;
                        r_nxt.ferr  = !rxd_in;
                    end
                end
                default: r_nxt.st = GMSP_B_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign rxi.data  = r.data;
    assign rxi.valid = r.valid;
    assign rxi.ferr  = r.ferr;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    AST_RX_PULSE: assert property (r.valid && ce_in |=> !r.valid)
        else $error("Receive valid lasted more than one cycle.");
    AST_RX_STOP_HIGH: assert property (r.st == GMSP_B_STOP && r.cnt == 16'h0 && ce_in && rxd_in
                                       |=> r.valid && r.data == $past(r.sh))
        else $error("Good stop bit did not deliver the character.");
endmodule

/* File: gmsp_host_model.sv */
// Purpose: Host terminal model: decodes the serial output, sends command bytes.
// Assumes: The bit time is bit_div_in system clock cycles, the same on both lines.
// Notes:   Sampling is at mid-bit on the system clock, so phase error is one cycle at most.
`timescale 1ns/1ns
module gmsp_host_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic        txd_in,
    input  wire logic [15:0] bit_div_in,
    output logic             rxd_out
);
    logic [7:0] rx_q[$];
    int         n_bad;
    logic [7:0] sh;

    initial begin
        rxd_out = 1'b1;
        n_bad = 0;
    end

    // Same rate as the module, 8N1, only the data line, start low, LSB first.
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_in);
            rxd_out <= fr[i];
            repeat (bit_div_in - 16'h1) @(posedge clk_sys_in);
        end
        @(posedge clk_sys_in);
        rxd_out <= 1'b1;
    endtask

    // The module's transmit line feeds our receive input; a bad start or stop is counted.
    initial begin
        forever begin
            @(posedge clk_sys_in iff (rst_b_in === 1'b1 && txd_in === 1'b0));
            repeat (bit_div_in / 16'h2) @(posedge clk_sys_in);
            if (txd_in !== 1'b0) begin
                n_bad++;
            end
            for (int i = 0; i < 8; i++) begin
                repeat (bit_div_in) @(posedge clk_sys_in);
                sh[i] = txd_in;
            end
            repeat (bit_div_in) @(posedge clk_sys_in);
            if (txd_in !== 1'b1) begin
                n_bad++;
            end
            rx_q.push_back(sh);
        end
    end
endmodule

/* File: test_gmsp_top.sv */
// Purpose: Self-checking bench of the receiver serial port.
// Assumes: CLK_HZ is lowered so that a bit at the reset rate lasts ten cycles.
// Notes:   The fastest rate is only set and reset away, as its divisor is a single cycle.
`timescale 1ns/1ns
module test_gmsp_top
    import gmsp_pkg::*;
;
    localparam int unsigned CLK_HZ = 1152000;
    logic        clk_sys_in;
    logic        rst_b_in;
    logic        rxd;
    logic        txd;
    logic        nav_update;
    logic        ce = 1'b1;
    logic        body_valid = 1'b0;
    logic        body_sel = 1'b0;
    logic        body_ready;
    logic [2:0]  type_idx;
    logic        busy;
    logic [7:0]  cmd_data;
    logic        cmd_valid;
    logic        frame_err;
    logic [2:0]  baud;
    logic [6:0]  mask;
    logic [15:0] div;
    logic [7:0]  last_cmd;
    int          n_cmd = 0;
    int          n_ferr = 0;
    int          errors;
    int          n_tests;
    int          rates[7] = '{9600, 14400, 19200, 38400, 57600, 115200, 961200};
    string       names[7] = '{"GGA", "GLL", "GSA", "GSV", "VTG", "RMC", "ZDA"};

    gmsp_top #(.CLK_HZ(CLK_HZ)) dut (
        .clk_sys_in    (clk_sys_in),
        .rst_b_in      (rst_b_in),
        .ce_in         (ce),
        .rxd_in        (rxd),
        .txd_out       (txd),
        .nav_update_in (nav_update),
        .body_data_in  ({7'h18, body_sel}),
        .body_valid_in (body_valid),
        .body_last_in  (body_sel),
        .body_ready_out(body_ready),
        .type_idx_out  (type_idx),
        .busy_out      (busy),
        .cmd_data_out  (cmd_data),
        .cmd_valid_out (cmd_valid),
        .frame_err_out (frame_err),
        .baud_code_out (baud),
        .type_mask_out (mask)
    );

    gmsp_host_model host (
        .clk_sys_in(clk_sys_in),
        .rst_b_in  (rst_b_in),
        .txd_in    (txd),
        .bit_div_in(div),
        .rxd_out   (rxd)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Each body is the two bytes "01"; the second one is marked last.
    // Valid rises only once ready is seen, so every body byte first meets a stall.
    always @(posedge clk_sys_in) begin
        if (body_ready === 1'b1 && body_valid === 1'b1) begin
            body_sel   <= ~body_sel;
            body_valid <= 1'b0;
        end else if (body_ready === 1'b1) begin
            body_valid <= 1'b1;
        end
        if (cmd_valid === 1'b1) begin
            n_cmd++;
            last_cmd = cmd_data;
        end
        if (frame_err === 1'b1) begin
            n_ferr++;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    task automatic results();
        $display("checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        div = 16'(CLK_HZ / rates[5]);
        check("txd idle", 1, txd);
        check("baud code", GMSP_BAUD_RST, baud);
        check("type mask", GMSP_MASK_RST, mask);
        check("busy", 0, busy);
        check("type index", 0, type_idx);
    endtask

    task automatic cmd(input logic [7:0] b, input logic stop);
        int c0;
        int f0;
        c0 = n_cmd;
        f0 = n_ferr;
        host.send(b, stop);
        repeat (4) @(posedge clk_sys_in);
        check("command count", c0 + int'(stop), n_cmd);
        check("frame error count", f0 + int'(!stop), n_ferr);
        if (stop) begin
            check("command byte", b, last_cmd);
        end
    endtask

    task automatic pulse();
        @(posedge clk_sys_in);
        nav_update <= 1'b1;
        @(posedge clk_sys_in);
        nav_update <= 1'b0;
    endtask

    // One update round; a second update while busy must add nothing.
    task automatic round(input logic [6:0] m);
        logic [7:0] exp[$];
        logic [7:0] cs;
        string      nm;
        int         k;
        for (int t = 0; t < 7; t++) begin
            if (m[t]) begin
                nm = {"GN", names[t], ",01"};
                cs = 8'h00;
                exp.push_back(8'h24);
                for (int i = 0; i < nm.len(); i++) begin
                    exp.push_back(nm[i]);
                    cs ^= nm[i];
                end
                exp.push_back(8'h2a);
                exp.push_back(hexc(cs[7:4]));
                exp.push_back(hexc(cs[3:0]));
                exp.push_back(8'h0d);
                exp.push_back(8'h0a);
            end
        end
        host.rx_q.delete();
        pulse();
        repeat (3) @(posedge clk_sys_in);
        check("busy after update", 1, busy);
        pulse();
        k = 0;
        while (busy === 1'b1 && k < 30000) begin
            @(posedge clk_sys_in);
            k++;
        end
        check("busy at end", 0, busy);
        repeat (12 * div) @(posedge clk_sys_in);
        check("sentence length", exp.size(), host.rx_q.size());
        foreach (exp[i]) begin
            if (i < host.rx_q.size()) begin
                check("sentence char", exp[i], host.rx_q[i]);
            end
        end
        check("framing faults", 0, host.n_bad);
    endtask

    // With the enable low nothing moves: an update and a command are both ignored.
    task automatic t_freeze();
        int c0;
        c0 = n_cmd;
        @(posedge clk_sys_in);
        ce <= 1'b0;
        pulse();
        host.send(8'h81, 1'b1);
        repeat (4) @(posedge clk_sys_in);
        check("busy frozen", 0, busy);
        check("ready frozen", 0, body_ready);
        check("txd frozen", 1, txd);
        check("mask frozen", GMSP_MASK_RST, mask);
        check("command count frozen", c0, n_cmd);
        ce <= 1'b1;
        @(posedge clk_sys_in);
    endtask

    // Walk through the rates, refuse an unlisted code, then reset from the fastest one.
    task automatic t_rates();
        for (int c = 0; c < 6; c++) begin
            cmd(8'h10 + 8'(c), 1'b1);
            check("rate code", c, baud);
            div = 16'(CLK_HZ / rates[c]);
        end
        cmd(8'h14, 1'b1);
        div = 16'(CLK_HZ / rates[4]);
        check("rate code", 4, baud);
        round(7'h05);
        cmd(8'h17, 1'b1);
        check("refused rate code", 4, baud);
        cmd(8'h16, 1'b1);
        check("top rate code", 6, baud);
        @(posedge clk_sys_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        t_reset();
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys_in);
        errors++;
        results();
    end

    initial begin
        rst_b_in = 1'b0;
        nav_update = 1'b0;
        errors = 0;
        n_tests = 0;
        div = 16'(CLK_HZ / rates[5]);
        repeat (12) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        t_reset();
        round(GMSP_MASK_RST);
        t_freeze();
        cmd(8'h85, 1'b0);
        check("mask after bad frame", GMSP_MASK_RST, mask);
        cmd(8'h85, 1'b1);
        check("mask command", 7'h05, mask);
        t_rates();
        cmd(8'h80, 1'b1);
        check("empty mask", 7'h00, mask);
        round(7'h00);
        results();
    end
endmodule
